// ==== dv/tb_watchdog_control_status_regs.sv ====
// Self-checking bench for the watchdog control/status block.
// Assumes wdcsr_top and its checker bind are compiled alongside.
`timescale 1ns/1ns
module tb_watchdog_control_status_regs;
	import wdcsr_pkg::*;
	logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, change_protect = 0, debug_mode = 0;
	logic cpu_halted = 0, wd_clock = 0, wd_restart_instr = 0, wd_sys_reset, lk_m;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, boot_config_fuse = 8'h00, reg_rdata, ctl_m, d;
	int fails = 0, n_compared = 0;
	wdcsr_top DUT (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .change_protect(change_protect),
		.debug_mode(debug_mode), .cpu_halted(cpu_halted), .boot_config_fuse(boot_config_fuse),
		.wd_clock(wd_clock), .wd_restart_instr(wd_restart_instr), .wd_sys_reset(wd_sys_reset));
	initial
	begin
		forever #50 mclk = ~mclk;
	end
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
		if (a == OFS_CONTROL && change_protect && !lk_m)
		begin
			ctl_m[7:4] = (v[7:4] <= 4'hB) ? v[7:4] : ctl_m[7:4];
			ctl_m[3:0] = (v[3:0] <= 4'hB) ? v[3:0] : ctl_m[3:0];
		end
		if (a == OFS_STATUS && change_protect && (v[7] || debug_mode))
			lk_m = v[7];
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// Ends with settle time so the last rise has been seen
	task automatic rises(input int n);
		repeat (n)
		begin
			repeat (4 + $urandom % 3) @(posedge mclk);
			wd_clock <= 1'b1;
			repeat (4 + $urandom % 3) @(posedge mclk);
			wd_clock <= 1'b0;
		end
		repeat (6) @(posedge mclk);
	endtask
	task automatic kick;
		@(posedge mclk);
		wd_restart_instr <= 1'b1;
		@(posedge mclk);
		wd_restart_instr <= 1'b0;
	endtask
	task automatic rst(input logic [7:0] f);
		@(posedge mclk);
		boot_config_fuse <= f;
		sys_rst <= 1'b1;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge mclk);
		ctl_m = f;
		lk_m = (f[3:0] != 4'h0);
	endtask
	initial
	begin
		#3000000;
		fails++;
		close_out;
	end
	initial
	begin
		void'($urandom(32'heb78));
		rst(8'h00);
		rd(OFS_CONTROL, 8'h00);
		rd(OFS_STATUS, 8'h00);
		wr(OFS_CONTROL, 8'h21);
		rd(OFS_CONTROL, ctl_m);
		change_protect <= 1'b1;
		// Window only: a live period would time out mid-loop
		repeat (4)
		begin
			d = 8'(($urandom % 12) << 4);
			wr(OFS_CONTROL, d);
			rd(OFS_STATUS, 8'h01);
			rises(2);
			rd(OFS_STATUS, 8'h00);
			rd(OFS_CONTROL, ctl_m);
		end
		wr(OFS_CONTROL, 8'hC0);
		rd(OFS_CONTROL, ctl_m);
		rises(2);
		change_protect <= 1'b0;
		wr(OFS_STATUS, 8'h80);
		rd(OFS_STATUS, 8'h00);
		change_protect <= 1'b1;
		wr(OFS_STATUS, 8'h80);
		wr(OFS_CONTROL, 8'h50);
		rd(OFS_STATUS, 8'h80);
		rd(OFS_CONTROL, ctl_m);
		wr(OFS_STATUS, 8'h00);
		rd(OFS_STATUS, 8'h80);
		debug_mode <= 1'b1;
		wr(OFS_STATUS, 8'h00);
		rd(OFS_STATUS, 8'h00);
		debug_mode <= 1'b0;
		wr(8'h02, 8'hFF);
		rd(8'h02, 8'h00);
		rst(8'h01);
		rd(OFS_STATUS, 8'h80);
		cpu_halted <= 1'b1;
		rises(10);
		cpu_halted <= 1'b0;
		chk({7'h00, wd_sys_reset}, 8'h00);
		rises(5);
		kick;
		// First rise takes the restart, seven more stay inside the period
		rises(8);
		chk({7'h00, wd_sys_reset}, 8'h00);
		rises(1);
		chk({7'h00, wd_sys_reset}, 8'h01);
		rst(8'h11);
		kick;
		rises(12);
		kick;
		rises(1);
		chk({7'h00, wd_sys_reset}, 8'h00);
		kick;
		rises(1);
		chk({7'h00, wd_sys_reset}, 8'h01);
		close_out;
	end
endmodule // tb_watchdog_control_status_regs

// ==== dv/wdcsr_properties.sv ====
// Port checker for the watchdog control/status block.
// Assumes it is bound to wdcsr_top.
`timescale 1ns/1ns
module wdcsr_properties
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [wdcsr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [wdcsr_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [wdcsr_pkg::DATA_W-1:0] reg_rdata,
	input wire logic change_protect,
	input wire logic debug_mode,
	input wire logic cpu_halted,
	input wire logic [wdcsr_pkg::DATA_W-1:0] boot_config_fuse,
	input wire logic wd_clock,
	input wire logic wd_restart_instr,
	input wire logic wd_sys_reset
);
	import wdcsr_pkg::*;
	logic lk_q, lk_d, rel_q, wr_ok;
	logic [7:0] ctl_q, ctl_d;
	assign wr_ok = reg_wr && reg_addr == OFS_CONTROL && change_protect && !lk_q;
	// Shadow of control and lock, for readback comparison
	always_comb
	begin
		ctl_d = ctl_q;
		lk_d = lk_q;
		if (wr_ok && reg_wdata[7:4] <= 4'hB)
			ctl_d[7:4] = reg_wdata[7:4];
		if (wr_ok && reg_wdata[3:0] <= 4'hB)
			ctl_d[3:0] = reg_wdata[3:0];
		if (reg_wr && reg_addr == OFS_STATUS && change_protect && (reg_wdata[7] || debug_mode))
			lk_d = reg_wdata[7];
		if (rel_q && boot_config_fuse[3:0] != 4'h0)
			lk_d = 1'b1;
		if (sys_rst)
		begin
			ctl_d = boot_config_fuse;
			lk_d = 1'b0;
		end
	end
	always_ff @(posedge mclk)
	begin
		ctl_q <= ctl_d;
		lk_q <= lk_d;
		rel_q <= sys_rst;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	sysreset_hold_a: assert property (wd_sys_reset |=> wd_sys_reset)
		else $error("system reset dropped");
	reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !wd_sys_reset && reg_rdata == 8'h00)
		else $error("outputs not cleared by reset");
	ctl_read_a: assert property (reg_rd && reg_addr == OFS_CONTROL |=> reg_rdata == $past(ctl_q))
		else $error("control readback wrong");
	lock_read_a: assert property (reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[7] == $past(lk_q))
		else $error("lock flag wrong");
	busy_set_a: assert property (wr_ok && reg_wdata[3:0] <= 4'hB ##2 reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[0])
		else $error("busy flag not raised");
	status_rsv_a: assert property (reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[6:1] == 6'h00)
		else $error("status spare bits set");
	unmapped_read_a: assert property (reg_rd && reg_addr > OFS_STATUS |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // wdcsr_properties
bind wdcsr_top wdcsr_properties chk (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.change_protect(change_protect), .debug_mode(debug_mode), .cpu_halted(cpu_halted),
	.boot_config_fuse(boot_config_fuse), .wd_clock(wd_clock),
	.wd_restart_instr(wd_restart_instr), .wd_sys_reset(wd_sys_reset));

// ==== verilog/wdcsr_pin_sync.sv ====
// Three-stage sampler for the watchdog clock pin, giving one-cycle rise pulses.
// Assumes the pin is slow against mclk.
`timescale 1ns/1ns
module wdcsr_pin_sync
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic pin_in,
	output logic rise
);
	logic s1_q, s2_q, s3_q, lvl_q;
	logic s1_d, s2_d, s3_d, lvl_d;

	always_comb
	begin
		s1_d = pin_in;
		s2_d = s1_q;
		s3_d = s2_q;
		// Only a level that two late stages agree on counts
		lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
		rise = lvl_d & ~lvl_q;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end
		else
		begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			lvl_q <= lvl_d;
		end
	end
endmodule // wdcsr_pin_sync

// ==== verilog/wdcsr_pkg.sv ====
// Constants, types and helpers shared by the watchdog control/status block.
// Assumes one system clock; the watchdog tick arrives as a sampled pin.
package wdcsr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int FIELD_W = 4;
	localparam int CNT_W = 14;
	localparam int SYNC_W = 2;

	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h01;
	localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

	localparam int CTL_PERIOD_LSB = 0;
	localparam int CTL_WINDOW_LSB = 4;
	localparam int STS_LOCK_BIT = 7;
	localparam int STS_BUSY_BIT = 0;

	localparam logic [FIELD_W-1:0] CODE_OFF = 4'h0;
	localparam logic [FIELD_W-1:0] CODE_MAX = 4'hB;
	localparam logic [FIELD_W-1:0] CODE_FIRST = 4'h1;
	localparam logic [CNT_W-1:0] BASE_CYCLES = 14'h0008;
	localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;

	// Watchdog clock edges needed to carry a new setting across
	localparam logic [SYNC_W-1:0] SYNC_TICKS = 2'h2;
	localparam logic [SYNC_W-1:0] SYNC_ONE = 2'h1;
	localparam logic [SYNC_W-1:0] SYNC_ZERO = 2'h0;

	typedef enum logic [2:0]
	{
		WDCSR_OFF = 3'b001,
		WDCSR_OPEN = 3'b010,
		WDCSR_CLOSED = 3'b100
	} wdcsr_state_t;

	function automatic logic wdcsr_code_ok(input logic [FIELD_W-1:0] code);
		wdcsr_code_ok = (code <= CODE_MAX);
	endfunction

	// Code 1 gives 8 cycles, each step doubles, code 0xB gives 8192
	function automatic logic [CNT_W-1:0] wdcsr_cycles(input logic [FIELD_W-1:0] code);
		wdcsr_cycles = BASE_CYCLES << (code - CODE_FIRST);
	endfunction

	function automatic logic [FIELD_W-1:0] wdcsr_period(input logic [DATA_W-1:0] cfg);
		wdcsr_period = cfg[CTL_PERIOD_LSB +: FIELD_W];
	endfunction

	function automatic logic [FIELD_W-1:0] wdcsr_window(input logic [DATA_W-1:0] cfg);
		wdcsr_window = cfg[CTL_WINDOW_LSB +: FIELD_W];
	endfunction
endpackage

// ==== verilog/wdcsr_top.sv ====
// Watchdog control and lock/sync status registers with the time-out engine.
// Assumes a CPU-side register port on mclk, a protect-unlock level from the
// CPU, and the slow watchdog clock arriving as a pin.
`timescale 1ns/1ns

module wdcsr_top
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [wdcsr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [wdcsr_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [wdcsr_pkg::DATA_W-1:0] reg_rdata,
	input wire logic change_protect,
	input wire logic debug_mode,
	input wire logic cpu_halted,
	input wire logic [wdcsr_pkg::DATA_W-1:0] boot_config_fuse,
	input wire logic wd_clock,
	input wire logic wd_restart_instr,
	output logic wd_sys_reset
);
	import wdcsr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	wdcsr_xfer_if xif ();

	logic tick;
	logic [DATA_W-1:0] ctl_q, ctl_d;
	logic lock_q, lock_d;
	logic boot_q, boot_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic wr_ctl, wr_sts, ctl_take;
	logic [FIELD_W-1:0] new_per, new_win;

	wdcsr_state_t st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic pend_q, pend_d;
	logic bark_q, bark_d;
	logic restart_now;
	logic [FIELD_W-1:0] act_per, act_win;
	logic enabled, windowed;
	logic [CNT_W-1:0] open_lim, closed_lim;

	////////////////////////////////////////////////////////////////////////
	// Watchdog clock pin and setting transfer

	wdcsr_pin_sync u_pin_sync
	(
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin_in(wd_clock),
		.rise(tick)
	);

	wdcsr_xfer u_xfer
	(
		.mclk(mclk),
		.sys_rst(sys_rst),
		.bus(xif)
	);

	assign xif.tick = tick;
	assign xif.load = ctl_take;
	assign xif.cfg_new = ctl_d;
	assign xif.boot_cfg = boot_config_fuse;

	////////////////////////////////////////////////////////////////////////
	// Register file

	always_comb
	begin
		wr_ctl = reg_wr && (reg_addr == OFS_CONTROL);
		wr_sts = reg_wr && (reg_addr == OFS_STATUS);
		// Protected and unlocked writes only
		ctl_take = wr_ctl && change_protect && !lock_q;
		new_per = wdcsr_period(reg_wdata);
		new_win = wdcsr_window(reg_wdata);
		ctl_d = ctl_q;
		if (ctl_take)
		begin
			// A reserved code leaves that field as it was
			if (wdcsr_code_ok(new_per))
			begin
				ctl_d[CTL_PERIOD_LSB +: FIELD_W] = new_per;
			end
			if (wdcsr_code_ok(new_win))
			begin
				ctl_d[CTL_WINDOW_LSB +: FIELD_W] = new_win;
			end
		end
	end

	always_comb
	begin
		boot_d = 1'b0;
		lock_d = lock_q;
		if (wr_sts && change_protect)
		begin
			if (reg_wdata[STS_LOCK_BIT])
			begin
				lock_d = 1'b1;
			end
			else if (debug_mode)
			begin
				lock_d = 1'b0;
			end
		end
		// Boot-time lock is applied after any clear, so it wins
		if (boot_q && (wdcsr_period(ctl_q) != CODE_OFF))
		begin
			lock_d = 1'b1;
		end
	end

	always_comb
	begin
		rdata_d = RDATA_IDLE;
		if (reg_rd)
		begin
			case (reg_addr)
				OFS_CONTROL:
				begin
					rdata_d = ctl_q;
				end
				OFS_STATUS:
				begin
					rdata_d = STATUS_RESET;
					rdata_d[STS_LOCK_BIT] = lock_q;
					rdata_d[STS_BUSY_BIT] = xif.busy;
				end
				default:
				begin
					rdata_d = RDATA_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			ctl_q <= boot_config_fuse;
			lock_q <= STATUS_RESET[STS_LOCK_BIT];
			boot_q <= 1'b1;
			rdata_q <= RDATA_IDLE;
		end
		else
		begin
			ctl_q <= ctl_d;
			lock_q <= lock_d;
			boot_q <= boot_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Time-out engine, counting watchdog clock edges

	always_comb
	begin
		act_per = wdcsr_period(xif.cfg_active);
		act_win = wdcsr_window(xif.cfg_active);
		enabled = (act_per != CODE_OFF);
		windowed = (act_win != CODE_OFF);
		open_lim = wdcsr_cycles(act_per);
		closed_lim = wdcsr_cycles(act_win);
	end

	always_comb
	begin
		// A restart is held until the next watchdog edge consumes it
		restart_now = pend_q || wd_restart_instr;
		pend_d = restart_now && !tick;
		st_d = st_q;
		cnt_d = cnt_q;
		bark_d = bark_q;
		if (cpu_halted)
		begin
			// Halt clears the count; first period after is a plain one
			cnt_d = CNT_ZERO;
			st_d = enabled ? WDCSR_OPEN : WDCSR_OFF;
		end
		else if (tick)
		begin
			case (st_q)
				WDCSR_OFF:
				begin
					cnt_d = CNT_ZERO;
					if (enabled)
					begin
						// A restart met on the way in must not be lost
						st_d = (restart_now && windowed) ? WDCSR_CLOSED : WDCSR_OPEN;
					end
				end
				WDCSR_OPEN:
				begin
					if (!enabled)
					begin
						st_d = WDCSR_OFF;
						cnt_d = CNT_ZERO;
					end
					else if (restart_now)
					begin
						cnt_d = CNT_ZERO;
						// Window only starts after the first restart
						st_d = windowed ? WDCSR_CLOSED : WDCSR_OPEN;
					end
					else if (cnt_q >= open_lim - CNT_ONE)
					begin
						bark_d = 1'b1;
					end
					else
					begin
						cnt_d = cnt_q + CNT_ONE;
					end
				end
				WDCSR_CLOSED:
				begin
					if (!enabled)
					begin
						st_d = WDCSR_OFF;
						cnt_d = CNT_ZERO;
					end
					else if (restart_now)
					begin
						bark_d = 1'b1;
					end
					else if (!windowed || (cnt_q >= closed_lim - CNT_ONE))
					begin
						st_d = WDCSR_OPEN;
						cnt_d = CNT_ZERO;
					end
					else
					begin
						cnt_d = cnt_q + CNT_ONE;
					end
				end
				default:
				begin
					st_d = WDCSR_OFF;
					cnt_d = CNT_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			st_q <= WDCSR_OFF;
			cnt_q <= CNT_ZERO;
			pend_q <= 1'b0;
			bark_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			pend_q <= pend_d;
			bark_q <= bark_d;
		end
	end

	// Held until the system reset comes back around
	assign wd_sys_reset = bark_q;
endmodule // wdcsr_top

// ==== verilog/wdcsr_xfer.sv ====
// Carries a written control value into the watchdog tick domain.
// Assumes one-cycle load pulses and tick pulses on mclk.
`timescale 1ns/1ns
module wdcsr_xfer
(
	input wire logic mclk,
	input wire logic sys_rst,
	wdcsr_xfer_if.xfer bus
);
	import wdcsr_pkg::*;

	logic [DATA_W-1:0] held_q, held_d, act_q, act_d;
	logic busy_q, busy_d;
	logic [SYNC_W-1:0] cnt_q, cnt_d;

	always_comb
	begin
		held_d = held_q;
		act_d = act_q;
		busy_d = busy_q;
		cnt_d = cnt_q;
		// A new load restarts the transfer with the latest value
		if (bus.load)
		begin
			held_d = bus.cfg_new;
			busy_d = 1'b1;
			cnt_d = SYNC_ZERO;
		end
		else if (busy_q && bus.tick)
		begin
			if (cnt_q == SYNC_TICKS - SYNC_ONE)
			begin
				act_d = held_q;
				busy_d = 1'b0;
			end
			else
			begin
				cnt_d = cnt_q + SYNC_ONE;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			held_q <= bus.boot_cfg;
			act_q <= bus.boot_cfg;
			busy_q <= 1'b0;
			cnt_q <= SYNC_ZERO;
		end
		else
		begin
			held_q <= held_d;
			act_q <= act_d;
			busy_q <= busy_d;
			cnt_q <= cnt_d;
		end
	end

	assign bus.cfg_active = act_q;
	assign bus.busy = busy_q;
endmodule // wdcsr_xfer

// ==== verilog/wdcsr_xfer_if.sv ====
// Bundle between the register file and the setting-transfer stage.
// Assumes both ends run on mclk.
`timescale 1ns/1ns
interface wdcsr_xfer_if;
	logic tick;
	logic load;
	logic [7:0] cfg_new;
	logic [7:0] boot_cfg;
	logic [7:0] cfg_active;
	logic busy;

	modport regs (output tick, output load, output cfg_new, output boot_cfg,
		input cfg_active, input busy);
	modport xfer (input tick, input load, input cfg_new, input boot_cfg,
		output cfg_active, output busy);
endinterface
